// ### core/fups_pkg.sv
// Purpose: constants for the flash unlock, program and erase sequencer
// Assumes: byte-wide register writes from the core or debugger, one clock
// Notes:   the array itself sits outside; this block drives its strobes
//
// Summary of operation
// - both protection option bits zero blocks all user program and erase
// - write-protect option one permits program and erase outside locked sectors
// - debugger mass erase still accepted with both option bits zero
// - reset puts the controller into its locked state
// - mismatching second page select relocks; match makes page active
// - 95H with page active erases it only if its sector is unprotected or the debugger writes it
// - any other command byte after unlock relocks the controller
// - mass erase rejected from user code, allowed only from debugger
// - after a byte program the page stays unlocked for more bytes
// - eight protection sectors of 1024 bytes, two erase pages each
// - 73H then 5EH routes next page-select write into sector lock mask
// - sector lock mask resets to zero; a one blocks its sector
// - set sector lock bits cannot be cleared by user code; reset or the debugger clears them
// - mass erase enable opens every address; page erase only its page
// - erased byte reads FFH; programming only clears bits
// - core stalled while a byte is programmed
// - page erase sets 512 bytes to FFH, core resumes, controller relocks
// - 63H with mass erase enabled erases all and relocks; debugger polls
// - status reads locked 000000, unlocked 000011, page erase 010xxx
// - seven-bit page field gives program address bits 15 to 9
package fups_pkg;
    // =======================================================
    // command bytes
    localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
    localparam logic [7:0] CMD_PAGE_ER = 8'h95;
    localparam logic [7:0] CMD_MASS_ER = 8'h63;
    localparam logic [7:0] CMD_SECTOR  = 8'h5E;
    // =======================================================
    // status codes
    localparam logic [5:0] ST_LOCKED   = 6'h00;
    localparam logic [5:0] ST_FIRST    = 6'h01;
    localparam logic [5:0] ST_SECOND   = 6'h02;
    localparam logic [5:0] ST_UNLOCKED = 6'h03;
    localparam logic [5:0] ST_SECT_SEL = 6'h04;
    localparam logic [5:0] ST_PROG     = 6'h08;
    localparam logic [5:0] ST_PAGE_ER  = 6'h10;
    localparam logic [5:0] ST_MASS_ER  = 6'h20;
    // =======================================================
    // geometry
    localparam int ADDR_W      = 16;
    localparam int PAGE_W      = 7;
    localparam int PAGE_LSB    = 9;
    localparam int SECTORS     = 8;
    localparam int SECTOR_LSB  = 10;
    localparam int SECT_IDX_W  = 3;
    localparam int PAGE_BYTES  = 512;
    localparam int ARRAY_BYTES = 8192;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    // =======================================================
    // timing: times in microseconds, cycles derived from the khz value
    localparam int PROG_TIME_US  = 40;
    localparam int PAGE_TIME_US  = 10000;
    localparam int MASS_TIME_US  = 20000;
    localparam int TIME_W        = 32;
    // =======================================================
    typedef enum logic [7:0] {
        FUPS_LOCKED   = 8'b0000_0001,
        FUPS_FIRST    = 8'b0000_0010,
        FUPS_SECOND   = 8'b0000_0100,
        FUPS_UNLOCKED = 8'b0000_1000,
        FUPS_SECT_SEL = 8'b0001_0000,
        FUPS_PROG     = 8'b0010_0000,
        FUPS_PAGE_ER  = 8'b0100_0000,
        FUPS_MASS_ER  = 8'b1000_0000
    } fups_state_t;
endpackage

// ### core/fups_timer.sv
// Purpose: wait counter for program and erase, sized from the khz value
// Assumes: start is a one-cycle pulse; khz value stable during a wait
// Notes:   cycles = khz * microseconds / 1000, at least one cycle
`timescale 1ns/100ps
module fups_timer
    import fups_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               start,
    input  wire logic [15:0]        khz,
    input  wire logic [fups_pkg::TIME_W-1:0] time_us,
    output logic                    done
);
    // =======================================================
    // counter
    logic [TIME_W-1:0] count;
    logic [TIME_W-1:0] next_count;
    logic              busy;
    logic              next_busy;
    logic              next_done;
    logic [47:0]       product;

    always_comb
    begin
        product    = 48'(khz) * 48'(time_us) / 48'd1000;
        next_count = count;
        next_busy  = busy;
        next_done  = 1'b0;
        if (start)
        begin
            next_busy  = 1'b1;
            // zero khz would mean no wait; keep one cycle minimum
            next_count = (product == 48'd0) ? TIME_W'(1) : product[TIME_W-1:0];
        end
        else if (busy)
        begin
            if (count <= TIME_W'(1))
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
            else
            begin
                next_count = count - TIME_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            busy  <= next_busy;
            done  <= next_done;
        end
    end
endmodule

// ### core/fups_ctrl.sv
// Purpose: flash controller sequencer: unlock, sector lock, program, erase
// Assumes: one-cycle write strobes from core or debugger; array outside
// Notes:   all outputs registered; array write strobes last one cycle
`timescale 1ns/100ps
module fups_ctrl
    import fups_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      debug_access,
    input  wire logic                      write_protect_option,
    input  wire logic                      secondary_protect_option,
    input  wire logic                      command_wr,
    input  wire logic                      page_select_wr,
    input  wire logic                      khz_high_wr,
    input  wire logic                      khz_low_wr,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      prog_req,
    input  wire logic [fups_pkg::ADDR_W-1:0] prog_addr,
    input  wire logic [7:0]                prog_data,
    input  wire logic [7:0]                array_rdata,
    output logic [5:0]                     controller_state_code,
    output logic [7:0]                     page_select_value,
    output logic [7:0]                     sector_lock_mask,
    output logic [15:0]                    clock_khz_value,
    output logic                           core_stall,
    output logic                           array_write,
    output logic                           array_page_erase,
    output logic                           array_mass_erase,
    output logic [fups_pkg::ADDR_W-1:0]    array_addr,
    output logic [7:0]                     array_wdata
);
    // =======================================================
    // decode helpers
    function automatic logic sector_locked(input logic [7:0] mask,
                                           input logic [ADDR_W-1:0] a);
        sector_locked = mask[a[SECTOR_LSB +: SECT_IDX_W]];
    endfunction

    function automatic logic [ADDR_W-1:0] page_base(input logic [7:0] ps);
        page_base = {ps[PAGE_W-1:0], {PAGE_LSB{1'b0}}};
    endfunction

    function automatic logic [5:0] status_code(input fups_state_t s);
        status_code = ST_LOCKED;
        unique case (s)
        FUPS_LOCKED:   status_code = ST_LOCKED;
        FUPS_FIRST:    status_code = ST_FIRST;
        FUPS_SECOND:   status_code = ST_SECOND;
        FUPS_UNLOCKED: status_code = ST_UNLOCKED;
        FUPS_SECT_SEL: status_code = ST_SECT_SEL;
        FUPS_PROG:     status_code = ST_PROG;
        FUPS_PAGE_ER:  status_code = ST_PAGE_ER;
        FUPS_MASS_ER:  status_code = ST_MASS_ER;
        endcase
    endfunction

    // =======================================================
    // state
    fups_state_t       state;
    fups_state_t       next_state;
    logic [7:0]        first_page;
    logic [7:0]        next_first_page;
    logic              page_en;
    logic              next_page_en;
    logic              mass_en;
    logic              next_mass_en;
    logic              erase_hold;
    logic              next_erase_hold;
    logic [7:0]        next_page_select;
    logic [7:0]        next_mask;
    logic [15:0]       next_khz;
    logic [5:0]        next_code;
    logic              next_stall;
    logic              next_write;
    logic              next_page_er;
    logic              next_mass_er;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0]        next_wdata;
    logic              timer_start;
    logic [TIME_W-1:0] timer_us;
    logic              timer_done;
    logic              user_ok;
    logic              addr_ok;

    // timer samples the value at start only; a reload mid-wait does not alter that wait
    fups_timer u_timer
    (
        .clk     (clk),
        .reset   (reset),
        .start   (timer_start),
        .khz     (clock_khz_value),
        .time_us (timer_us),
        .done    (timer_done)
    );

    // =======================================================
    // clock value; software may reload it in any state
    always_comb
    begin
        next_khz = clock_khz_value;
        if (khz_high_wr)
            next_khz[15:8] = wr_data;
        if (khz_low_wr)
            next_khz[7:0] = wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            clock_khz_value <= '0;
        end
        else
        begin
            clock_khz_value <= next_khz;
        end
    end

    // =======================================================
    // sequencer
    always_comb
    begin
        next_state       = state;
        next_first_page  = first_page;
        next_page_en     = page_en;
        next_mass_en     = mass_en;
        next_erase_hold  = erase_hold;
        next_page_select = page_select_value;
        next_mask        = sector_lock_mask;
        next_write       = 1'b0;
        next_page_er     = 1'b0;
        next_mass_er     = 1'b0;
        next_addr        = array_addr;
        next_wdata       = array_wdata;
        timer_start      = 1'b0;
        timer_us         = TIME_W'(PROG_TIME_US);
        // write-protect option gates user code only; debugger bypasses it
        user_ok = debug_access || write_protect_option;
        addr_ok = mass_en ||
                  (page_en && prog_addr[ADDR_W-1:PAGE_LSB] ==
                   page_select_value[PAGE_W-1:0]);

        unique case (state)
        FUPS_LOCKED:
        begin
            if (page_select_wr)
            begin
                next_page_select = wr_data;
                next_first_page  = wr_data;
            end
            if (command_wr && wr_data == CMD_UNLOCK1)
                next_state = FUPS_FIRST;
        end
        FUPS_FIRST:
        begin
            if (command_wr)
            begin
                if (wr_data == CMD_UNLOCK2)
                    next_state = FUPS_SECOND;
                else if (wr_data == CMD_SECTOR)
                    next_state = FUPS_SECT_SEL;
                else
                    next_state = FUPS_LOCKED;
            end
        end
        FUPS_SECOND:
        begin
            if (page_select_wr)
            begin
                next_page_select = wr_data;
                if (wr_data == first_page)
                begin
                    next_state   = FUPS_UNLOCKED;
                    next_page_en = 1'b1;
                end
                else
                    next_state = FUPS_LOCKED;
            end
            else if (command_wr)
                next_state = FUPS_LOCKED;
            else if (debug_access)
                next_state = FUPS_UNLOCKED; // debugger skips the re-write
        end
        FUPS_SECT_SEL:
        begin
            if (page_select_wr)
            begin
                // user code may only set bits; debugger may also clear
                next_mask  = debug_access ? wr_data
                                          : (sector_lock_mask | wr_data);
                next_state = FUPS_LOCKED;
            end
            else if (command_wr)
                next_state = FUPS_LOCKED;
        end
        FUPS_UNLOCKED:
        begin
            if (command_wr)
            begin
                if (wr_data == CMD_PAGE_ER && user_ok && !erase_hold &&
                    (debug_access ||
                     !sector_locked(sector_lock_mask,
                                    page_base(page_select_value))))
                begin
                    next_state   = FUPS_PAGE_ER;
                    next_page_er = 1'b1;
                    next_addr    = page_base(page_select_value);
                    timer_start  = 1'b1;
                    timer_us     = TIME_W'(PAGE_TIME_US);
                end
                else if (wr_data == CMD_MASS_ER && debug_access)
                begin
                    next_state   = FUPS_MASS_ER;
                    next_mass_en = 1'b1;
                    next_mass_er = 1'b1;
                    timer_start  = 1'b1;
                    timer_us     = TIME_W'(MASS_TIME_US);
                end
                else
                begin
                    next_state   = FUPS_LOCKED;
                    next_page_en = 1'b0;
                    next_mass_en = 1'b0;
                end
            end
            else if (page_select_wr && debug_access)
                next_page_select = wr_data;
            else if (prog_req && user_ok &&
                     (debug_access || (addr_ok &&
                      !sector_locked(sector_lock_mask, prog_addr))))
            begin
                next_state  = FUPS_PROG;
                next_write  = 1'b1;
                next_addr   = prog_addr;
                next_wdata  = array_rdata & prog_data;
                timer_start = 1'b1;
            end
        end
        FUPS_PROG:
        begin
            if (timer_done)
                next_state = FUPS_UNLOCKED;
        end
        FUPS_PAGE_ER, FUPS_MASS_ER:
        begin
            if (timer_done)
            begin
                next_state   = FUPS_LOCKED;
                next_page_en = 1'b0;
                next_mass_en = 1'b0;
            end
        end
        endcase

        if (state == FUPS_LOCKED)
            next_erase_hold = 1'b0;

        next_code  = status_code(next_state);
        // stall follows the next state so it rises with the strobe
        next_stall = (next_state == FUPS_PROG) ||
                     (next_state == FUPS_PAGE_ER) ||
                     (next_state == FUPS_MASS_ER);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state                 <= FUPS_LOCKED;
            first_page            <= '0;
            page_en               <= 1'b0;
            mass_en               <= 1'b0;
            erase_hold            <= 1'b0;
            page_select_value     <= '0;
            sector_lock_mask      <= MASK_RESET;
            controller_state_code <= ST_LOCKED;
            core_stall            <= 1'b0;
            array_write           <= 1'b0;
            array_page_erase      <= 1'b0;
            array_mass_erase      <= 1'b0;
            array_addr            <= '0;
            array_wdata           <= ERASED_BYTE;
        end
        else
        begin
            state                 <= next_state;
            first_page            <= next_first_page;
            page_en               <= next_page_en;
            mass_en               <= next_mass_en;
            erase_hold            <= next_erase_hold;
            page_select_value     <= next_page_select;
            sector_lock_mask      <= next_mask;
            controller_state_code <= next_code;
            core_stall            <= next_stall;
            array_write           <= next_write;
            array_page_erase      <= next_page_er;
            array_mass_erase      <= next_mass_er;
            array_addr            <= next_addr;
            array_wdata           <= next_wdata;
        end
    end
endmodule

// ### dv/fups_ctrl_monitor.sv
// Purpose: port assertions for the flash sequencer
// Assumes: one clock, synchronous active high reset
// Notes:   sees fups_ctrl ports only; bound below
`timescale 1ns/100ps
module fups_ctrl_monitor
    import fups_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        debug_access,
    input wire logic        write_protect_option,
    input wire logic        command_wr,
    input wire logic        page_select_wr,
    input wire logic [7:0]  wr_data,
    input wire logic        prog_req,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0]  prog_data,
    input wire logic [7:0]  array_rdata,
    input wire logic [5:0]  controller_state_code,
    input wire logic [7:0]  page_select_value,
    input wire logic [7:0]  sector_lock_mask,
    input wire logic        core_stall,
    input wire logic        array_write,
    input wire logic        array_page_erase,
    input wire logic [15:0] array_addr,
    input wire logic [7:0]  array_wdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ====================================================
    // sequencing and protection
    a_reset_locked: assert property ($fell(reset) |-> controller_state_code == ST_LOCKED)
        else $error("not locked after reset");
    a_unlock_match: assert property (controller_state_code == ST_SECOND && page_select_wr
        && !command_wr && !debug_access && wr_data == page_select_value
        |=> controller_state_code == ST_UNLOCKED) else $error("matching page did not unlock");
    a_other_cmd_lock: assert property (controller_state_code == ST_UNLOCKED && command_wr
        && !page_select_wr && !debug_access && wr_data != CMD_PAGE_ER
        |=> controller_state_code == ST_LOCKED) else $error("command did not relock");
    a_mask_sticky: assert property (!$past(debug_access)
        |-> (sector_lock_mask & $past(sector_lock_mask)) == $past(sector_lock_mask))
        else $error("lock bit cleared");
    a_locked_no_write: assert property (prog_req && controller_state_code == ST_LOCKED
        |=> !array_write) else $error("write while locked");
    a_wp_blocks: assert property (prog_req && !debug_access && !write_protect_option
        |=> !array_write) else $error("write with protection");
    a_sector_blocks: assert property (prog_req && !debug_access
        && sector_lock_mask[prog_addr[12:10]] |=> !array_write) else $error("locked sector written");
    a_write_data: assert property (array_write |-> core_stall
        && array_addr == $past(prog_addr)
        && array_wdata == ($past(prog_data) & $past(array_rdata))) else $error("bad array write");
    a_erase_start: assert property (command_wr && wr_data == CMD_PAGE_ER && !debug_access
        && write_protect_option && controller_state_code == ST_UNLOCKED && !page_select_wr
        && !sector_lock_mask[page_select_value[3:1]] |=> array_page_erase && core_stall
        && controller_state_code == ST_PAGE_ER && array_addr[15:9] == page_select_value[6:0])
        else $error("page erase not started");
    a_erase_relocks: assert property ($past(controller_state_code) == ST_PAGE_ER
        && controller_state_code != ST_PAGE_ER |-> controller_state_code == ST_LOCKED)
        else $error("erase did not relock");
endmodule
bind fups_ctrl fups_ctrl_monitor i_fups_ctrl_monitor (
    .clk(clk), .reset(reset), .debug_access(debug_access),
    .write_protect_option(write_protect_option), .command_wr(command_wr),
    .page_select_wr(page_select_wr), .wr_data(wr_data), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_data(prog_data), .array_rdata(array_rdata),
    .controller_state_code(controller_state_code), .page_select_value(page_select_value),
    .sector_lock_mask(sector_lock_mask), .core_stall(core_stall), .array_write(array_write),
    .array_page_erase(array_page_erase), .array_addr(array_addr), .array_wdata(array_wdata)
);

// ### dv/fups_flash_model.sv
// Purpose: behavioural flash array beside the sequencer
// Assumes: strobes last one cycle; erase lands at once
// Notes:   13 address bits decode the 8 KB array
`timescale 1ns/100ps
module fups_flash_model
    import fups_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        array_write,
    input  wire logic        array_page_erase,
    input  wire logic        array_mass_erase,
    input  wire logic [15:0] array_addr,
    input  wire logic [7:0]  array_wdata,
    input  wire logic [15:0] prog_addr,
    output logic [7:0]       array_rdata
);
    logic [7:0] mem [0:ARRAY_BYTES-1];
    // ====================================================
    // storage: a write can only clear bits, like real cells
    initial
        foreach (mem[i])
            mem[i] = ERASED_BYTE;
    always @(posedge clk)
    begin
        if (array_write)
            mem[array_addr[12:0]] <= mem[array_addr[12:0]] & array_wdata;
        if (array_page_erase || array_mass_erase)
            foreach (mem[i])
                if (array_mass_erase || i[12:9] == array_addr[12:9])
                    mem[i] <= ERASED_BYTE;
    end
    assign array_rdata = mem[prog_addr[12:0]];
endmodule

// ### dv/fups_ctrl_tb.sv
// Purpose: directed test of the flash sequencer
// Assumes: khz value 1 keeps every wait short
// Notes:   array bytes are read from the model
`timescale 1ns/100ps
module fups_ctrl_tb;
    import fups_pkg::*;
    logic        clk, reset, debug_access, write_protect_option, secondary_protect_option;
    logic        command_wr, page_select_wr, khz_high_wr, khz_low_wr, prog_req, core_stall;
    logic        array_write, array_page_erase, array_mass_erase;
    logic [5:0]  controller_state_code;
    logic [7:0]  wr_data, prog_data, array_rdata, page_select_value, sector_lock_mask, array_wdata;
    logic [15:0] prog_addr, clock_khz_value, array_addr;
    int          mismatches, checks_done;
    fups_ctrl i_fups_ctrl (
        .clk(clk), .reset(reset), .debug_access(debug_access),
        .write_protect_option(write_protect_option), .command_wr(command_wr),
        .secondary_protect_option(secondary_protect_option), .page_select_wr(page_select_wr),
        .khz_high_wr(khz_high_wr), .khz_low_wr(khz_low_wr), .wr_data(wr_data),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
        .array_rdata(array_rdata), .controller_state_code(controller_state_code),
        .page_select_value(page_select_value), .sector_lock_mask(sector_lock_mask),
        .clock_khz_value(clock_khz_value), .core_stall(core_stall), .array_write(array_write),
        .array_page_erase(array_page_erase), .array_mass_erase(array_mass_erase),
        .array_addr(array_addr), .array_wdata(array_wdata));
    fups_flash_model i_fups_flash_model (
        .clk(clk), .array_write(array_write), .array_page_erase(array_page_erase),
        .array_mass_erase(array_mass_erase), .array_addr(array_addr),
        .array_wdata(array_wdata), .prog_addr(prog_addr), .array_rdata(array_rdata));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic st(input logic [5:0] e);
        chk("state code", 16'(e), 16'(controller_state_code));
    endtask
    task automatic byte_is(input logic [15:0] a, input logic [7:0] e);
        chk("array byte", 16'(e), 16'(i_fups_flash_model.mem[a[12:0]]));
    endtask
    // which: 0 command, 1 page select, 2 khz high, 3 khz low
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge clk);
        wr_data = d;
        {command_wr, page_select_wr, khz_high_wr, khz_low_wr} = 4'h8 >> which;
        @(negedge clk);
        {command_wr, page_select_wr, khz_high_wr, khz_low_wr} = 4'h0;
    endtask
    // bounded, so a stall that never ends still reaches the verdict
    task automatic settle();
        int n;
        n = 0;
        while (core_stall !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk("core stall", 16'h0000, 16'(core_stall));
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        {prog_req, prog_addr, prog_data} = {1'b1, a, d};
        @(negedge clk);
        prog_req = 1'b0;
        settle();
    endtask
    task automatic unlock(input logic [7:0] p, input logic [7:0] q);
        wr(1, p);
        wr(0, CMD_UNLOCK1);
        wr(0, CMD_UNLOCK2);
        wr(1, q);
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        {reset, debug_access, write_protect_option, secondary_protect_option} = 4'hB;
        {command_wr, page_select_wr, khz_high_wr, khz_low_wr, prog_req} = 5'h00;
        {wr_data, prog_addr, prog_data, mismatches, checks_done} = '0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        st(ST_LOCKED);
        chk("lock mask", 16'h0000, 16'(sector_lock_mask));
        wr(2, 8'h00);
        wr(3, 8'h01);
        chk("khz value", 16'h0001, clock_khz_value);
        prog(16'h0400, 8'h00);
        byte_is(16'h0400, 8'hFF);
        wr(1, 8'h02);
        wr(0, CMD_UNLOCK1);
        st(ST_FIRST);
        wr(0, CMD_UNLOCK2);
        st(ST_SECOND);
        wr(1, 8'h02);
        st(ST_UNLOCKED);
        prog(16'h0401, 8'hA5);
        byte_is(16'h0401, 8'hA5);
        st(ST_UNLOCKED);
        prog(16'h0401, 8'h0F);
        byte_is(16'h0401, 8'h05);
        prog(16'h0600, 8'h00);
        byte_is(16'h0600, 8'hFF);
        wr(0, CMD_PAGE_ER);
        st(ST_PAGE_ER);
        chk("core stall", 16'h0001, 16'(core_stall));
        settle();
        byte_is(16'h0401, 8'hFF);
        st(ST_LOCKED);
        unlock(8'h02, 8'h03);
        st(ST_LOCKED);
        unlock(8'h04, 8'h04);
        prog(16'h0800, 8'h3C);
        wr(0, 8'h11);
        st(ST_LOCKED);
        for (int i = 0; i < 2; i++)
        begin
            wr(0, CMD_UNLOCK1);
            wr(0, CMD_SECTOR);
            wr(1, (i == 0) ? 8'h04 : 8'h00);
            chk("lock mask", 16'h0004, 16'(sector_lock_mask));
        end
        unlock(8'h04, 8'h04);
        prog(16'h0801, 8'h00);
        byte_is(16'h0801, 8'hFF);
        wr(0, CMD_PAGE_ER);
        settle();
        byte_is(16'h0800, 8'h3C);
        {write_protect_option, secondary_protect_option} = 2'h0;
        unlock(8'h02, 8'h02);
        prog(16'h0410, 8'h00);
        byte_is(16'h0410, 8'hFF);
        wr(0, CMD_MASS_ER);
        settle();
        byte_is(16'h0800, 8'h3C);
        debug_access = 1'b1;
        wr(0, CMD_UNLOCK1);
        wr(0, CMD_UNLOCK2);
        wr(0, CMD_MASS_ER);
        st(ST_MASS_ER);
        settle();
        byte_is(16'h0800, 8'hFF);
        st(ST_LOCKED);
        report_and_stop();
    end
endmodule
